// ==== wtt_write_timing.sv ====
// write path timing of the memory device: burst length, write latency, recovery and turnaround
// Operation
// R1 - controller waits latency plus 4 or 2 clocks plus recovery before precharge.
// R2 - controller also honours activate-to-precharge minimum before precharge after write; here that minimum is neither timed nor flagged.
// R3 - recovery counts from edge after last beat and gates precharge acceptance; here early precharge closes a bank not auto precharging and only sets a flag.
// R4 - controller delays read after write by short or long turnaround.
// R5 - eight-beat burst for mode 00, or mode 01 with address bit 12 high.
// R6 - mode 01 with address bit 12 low chops burst to four beats.
// R7 - mode 10 chops every burst to four beats, fixed.
// R8 - two-clock preamble forbids write latency setting 9.
// R9 - crc with two-clock preamble forbids writes six clocks apart.
// R10 - write data arrives additive plus write latency clocks after command.
// R11 - bus inversion enabled selects its own recovery time.
// R12 - crc with mask selects its own recovery and turnaround times.
// R13 - address bit 10 high auto precharges after burst; low keeps bank open.
// R14 - mask and bus inversion must never be enabled together.
// R15 - short turnaround for other bank group, long for same group.
`timescale 1ns/1ps
`default_nettype none
module wtt_write_timing
   import wtt_pkg::*;
(
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_we,
   input  wire logic              reg_re,
   output logic       [DATA_W-1:0] reg_rdata,
   // command
   input  wire logic              cmd_act,
   input  wire logic              cmd_wr,
   input  wire logic              cmd_rd,
   input  wire logic              cmd_pre,
   input  wire logic [BANK_W-1:0] cmd_bank,
   input  wire logic              cmd_a10,
   input  wire logic              cmd_a12,
   // write data window and bank state
   output logic                   wdata_valid,
   output logic                   wdata_chop,
   output logic       [BANK_W-1:0] wdata_bank,
   output logic       [NBANK-1:0]  ap_done,
   output logic       [NBANK-1:0]  bank_open
);

   // ********************************************
   // configuration registers
   // ********************************************
   logic [1:0]       bl_mode_r;
   logic             dbi_en_r;
   logic             crc_en_r;
   logic             dm_en_r;
   logic             pre2_r;
   logic [LAT_W-1:0] al_r;
   logic [LAT_W-1:0] cwl_r;
   logic [TMR_W-1:0] twr_cfg_r;
   logic [TMR_W-1:0] twr_dbi_cfg_r;
   logic [TMR_W-1:0] twr_crc_cfg_r;
   logic [TMR_W-1:0] twtr_s_cfg_r;
   logic [TMR_W-1:0] twtr_l_cfg_r;
   logic [TMR_W-1:0] twtr_s_crc_cfg_r;
   logic [TMR_W-1:0] twtr_l_crc_cfg_r;
   logic [FLG_W-1:0] flags_r;
   logic [FLG_W-1:0] flag_set;
   logic [FLG_W-1:0] flag_clr;
   logic [DATA_W-1:0] rdata_nxt;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         bl_mode_r        <= BL_MODE_RST;
         dbi_en_r         <= 1'b0;
         crc_en_r         <= 1'b0;
         dm_en_r          <= 1'b0;
         pre2_r           <= 1'b0;
         al_r             <= AL_RST;
         cwl_r            <= CWL_RST;
         twr_cfg_r        <= TWR_RST;
         twr_dbi_cfg_r    <= TWR_DBI_RST;
         twr_crc_cfg_r    <= TWR_CRC_RST;
         twtr_s_cfg_r     <= TWTR_S_RST;
         twtr_l_cfg_r     <= TWTR_L_RST;
         twtr_s_crc_cfg_r <= TWTR_S_CRC_RST;
         twtr_l_crc_cfg_r <= TWTR_L_CRC_RST;
      end else if (reg_we) begin
         case (reg_addr)
            REG_MODE: begin
               bl_mode_r <= reg_wdata[MODE_BL_LSB +: 2];
               dbi_en_r  <= reg_wdata[MODE_DBI];
               crc_en_r  <= reg_wdata[MODE_CRC];
               dm_en_r   <= reg_wdata[MODE_DM];
               pre2_r    <= reg_wdata[MODE_PRE2];
            end
            REG_LAT: begin
               al_r  <= reg_wdata[LAT_AL_LSB +: LAT_W];
               cwl_r <= reg_wdata[LAT_CWL_LSB +: LAT_W];
            end
            REG_TWR: begin
               twr_cfg_r     <= reg_wdata[FLD0_LSB +: TMR_W];
               twr_dbi_cfg_r <= reg_wdata[FLD1_LSB +: TMR_W];
               twr_crc_cfg_r <= reg_wdata[FLD2_LSB +: TMR_W];
            end
            REG_TWTR: begin
               twtr_s_cfg_r     <= reg_wdata[FLD0_LSB +: TMR_W];
               twtr_l_cfg_r     <= reg_wdata[FLD1_LSB +: TMR_W];
               twtr_s_crc_cfg_r <= reg_wdata[FLD2_LSB +: TMR_W];
               twtr_l_crc_cfg_r <= reg_wdata[FLD3_LSB +: TMR_W];
            end
            default: begin
            end
         endcase
      end
   end

   // ********************************************
   // write latency pipeline
   // ********************************************
   logic [SR_W-1:0]   sr_r [SR_DEPTH];
   logic [5:0]        wl;
   logic [5:0]        tap_idx;
   logic [SR_W-1:0]   tap;
   logic              new_otf;
   logic              new_fix;

   assign new_fix = (bl_mode_r == BL_MODE_BC4); // R7
   assign new_otf = (bl_mode_r == BL_MODE_OTF) && !cmd_a12; // R5 R6
   assign wl      = {1'b0, al_r} + {1'b0, cwl_r}; // R10
   // registered window output needs the entry one cycle before the latency is reached
   assign tap_idx = (wl < WL_TAP_OFS) ? 6'h00 : wl - WL_TAP_OFS;
   assign tap     = sr_r[tap_idx];

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         for (int i = 0; i < SR_DEPTH; i++) begin
            sr_r[i] <= '0;
         end
      end else begin
         sr_r[0] <= cmd_wr ? {1'b1, cmd_bank, new_otf, new_fix} : '0;
         for (int i = 1; i < SR_DEPTH; i++) begin
            sr_r[i] <= sr_r[i-1];
         end
      end
   end

   // ********************************************
   // burst engine
   // ********************************************
   logic              win_r;
   logic              otf_r;
   logic [2:0]        cnt_r;
   logic              burst_done;

   // an on-the-fly chop keeps the full four-clock slot, only its beats stop early
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         win_r       <= 1'b0;
         wdata_valid <= 1'b0;
         wdata_chop  <= 1'b0;
         wdata_bank  <= '0;
         otf_r       <= 1'b0;
         cnt_r       <= 3'h0;
      end else if (tap[E_V]) begin
         win_r       <= 1'b1; // R10
         wdata_valid <= 1'b1;
         wdata_bank  <= tap[E_BANK_LSB +: BANK_W];
         wdata_chop  <= tap[E_OTF] | tap[E_FIX]; // R6 R7
         otf_r       <= tap[E_OTF];
         cnt_r       <= tap[E_FIX] ? BURST_CLK_BC4 - 3'h1 : BURST_CLK_8 - 3'h1; // R1 R5 R7
      end else if (win_r && cnt_r != 3'h0) begin
         cnt_r <= cnt_r - 3'h1;
         if (otf_r && cnt_r == BURST_CLK_BC4) begin
            wdata_valid <= 1'b0; // R6
         end
      end else begin
         win_r       <= 1'b0;
         wdata_valid <= 1'b0;
      end
   end

   assign burst_done = win_r && (cnt_r == 3'h0);

   // ********************************************
   // recovery and turnaround selection
   // ********************************************
   logic             crc_dm;
   logic [TMR_W-1:0] twr_sel;
   logic [TMR_W-1:0] wtr_s_cnt_r;
   logic [TMR_W-1:0] wtr_l_cnt_r;
   logic             last_bg_r;
   logic [3:0]       since_r;
   logic [NBANK-1:0] bank_busy;

   assign crc_dm  = crc_en_r && dm_en_r;
   assign twr_sel = crc_dm ? twr_crc_cfg_r : (dbi_en_r ? twr_dbi_cfg_r : twr_cfg_r); // R11 R12

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wtr_s_cnt_r <= '0;
         wtr_l_cnt_r <= '0;
         last_bg_r   <= 1'b0;
      end else if (burst_done) begin
         wtr_s_cnt_r <= crc_dm ? twtr_s_crc_cfg_r : twtr_s_cfg_r; // R4 R12
         wtr_l_cnt_r <= crc_dm ? twtr_l_crc_cfg_r : twtr_l_cfg_r; // R4 R12
         last_bg_r   <= wdata_bank[BG_BIT];
      end else begin
         if (wtr_s_cnt_r != '0) begin
            wtr_s_cnt_r <= wtr_s_cnt_r - 8'h01;
         end
         if (wtr_l_cnt_r != '0) begin
            wtr_l_cnt_r <= wtr_l_cnt_r - 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         since_r <= 4'hF;
      end else if (cmd_wr) begin
         since_r <= 4'h0;
      end else if (since_r != 4'hF) begin
         since_r <= since_r + 4'h1;
      end
   end

   // ********************************************
   // banks
   // ********************************************
   for (genvar g = 0; g < NBANK; g++) begin : g_bank
      wtt_bank u_bank (
         .ref_clk    (ref_clk),
         .nrst       (nrst),
         .act        (cmd_act && cmd_bank == BANK_W'(g)),
         .wr         (cmd_wr && cmd_bank == BANK_W'(g)),
         .ap         (cmd_a10),
         .pre        (cmd_pre && cmd_bank == BANK_W'(g)),
         .burst_done (burst_done && wdata_bank == BANK_W'(g)),
         .twr_val    (twr_sel),
         .bank_open  (bank_open[g]),
         .bank_busy  (bank_busy[g]),
         .ap_pulse   (ap_done[g])
      );
   end

   // ********************************************
   // sticky fault flags, write one to clear
   // ********************************************
   // the bank is closed even on an early precharge unless an auto precharge is pending; the flag only reports it
   assign flag_set[FLG_TWR]   = cmd_pre && bank_busy[cmd_bank]; // R3
   assign flag_set[FLG_WTR]   = cmd_rd && (wtr_s_cnt_r != '0 ||
                                (cmd_bank[BG_BIT] == last_bg_r && wtr_l_cnt_r != '0)); // R4 R15
   assign flag_set[FLG_CWL]   = pre2_r && (cwl_r <= CWL_MIN); // R8
   assign flag_set[FLG_CCD]   = cmd_wr && crc_en_r && pre2_r && (since_r == CCD_FORBID - 4'h1); // R9
   assign flag_set[FLG_DMDBI] = dm_en_r && dbi_en_r; // R14
   assign flag_clr = (reg_we && reg_addr == REG_FLAG) ? reg_wdata[FLG_W-1:0] : '0;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         flags_r <= '0;
      end else begin
         flags_r <= (flags_r & ~flag_clr) | flag_set;
      end
   end

   // ********************************************
   // read back
   // ********************************************
   always_comb begin
      rdata_nxt = '0;
      case (reg_addr)
         REG_MODE: begin
            rdata_nxt[MODE_BL_LSB +: 2] = bl_mode_r;
            rdata_nxt[MODE_DBI]         = dbi_en_r;
            rdata_nxt[MODE_CRC]         = crc_en_r;
            rdata_nxt[MODE_DM]          = dm_en_r;
            rdata_nxt[MODE_PRE2]        = pre2_r;
         end
         REG_LAT: begin
            rdata_nxt[LAT_AL_LSB +: LAT_W]  = al_r;
            rdata_nxt[LAT_CWL_LSB +: LAT_W] = cwl_r;
         end
         REG_TWR:  rdata_nxt = {8'h00, twr_crc_cfg_r, twr_dbi_cfg_r, twr_cfg_r};
         REG_TWTR: rdata_nxt = {twtr_l_crc_cfg_r, twtr_s_crc_cfg_r, twtr_l_cfg_r, twtr_s_cfg_r};
         REG_STAT: begin
            rdata_nxt[STAT_OPEN +: NBANK] = bank_open;
            rdata_nxt[STAT_BUSY +: NBANK] = bank_busy;
            rdata_nxt[STAT_WIN]           = win_r;
         end
         REG_FLAG: rdata_nxt[FLG_W-1:0] = flags_r;
         default:  rdata_nxt = '0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_re ? rdata_nxt : '0;
      end
   end

   // ********************************************
   // checks
   // ********************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   a_data_start: assert property (tap[E_V] |=> wdata_valid && wdata_bank == $past(tap[E_BANK_LSB +: BANK_W])) // R10
      else $error("write data window not opened at write latency");
   a_bl8_beats: assert property ($rose(wdata_valid) && !wdata_chop |-> wdata_valid[*4]) // R5
      else $error("eight-beat burst shorter than four clocks");
   a_otf_chop: assert property ($rose(win_r) && otf_r |-> wdata_valid[*2] ##1 !wdata_valid ##1 burst_done) // R6
      else $error("on-the-fly chop beats or slot wrong");
   a_fixed_chop: assert property ($rose(win_r) && wdata_chop && !otf_r |-> ##1 burst_done) // R7
      else $error("fixed chop slot not two clocks");
   a_twr_early: assert property (cmd_pre && bank_busy[cmd_bank] |=> flags_r[FLG_TWR]) // R3
      else $error("early precharge not flagged");
   a_wtr_long: assert property (cmd_rd && cmd_bank[BG_BIT] == last_bg_r && wtr_l_cnt_r != '0
                                |=> flags_r[FLG_WTR]) // R15
      else $error("same group read inside long turnaround not flagged");
   a_twr_dbi: assert property (burst_done && dbi_en_r && !crc_dm |-> twr_sel == twr_dbi_cfg_r) // R11
      else $error("inversion recovery time not selected");
   a_wtr_crc_dm: assert property (burst_done && crc_dm |=> wtr_s_cnt_r == twtr_s_crc_cfg_r
                                  && wtr_l_cnt_r == twtr_l_crc_cfg_r) // R12
      else $error("crc with mask turnaround not selected");
   a_cwl_flag: assert property (pre2_r && cwl_r == CWL_MIN |=> flags_r[FLG_CWL]) // R8
      else $error("forbidden latency with long preamble not flagged");
   a_ccd_flag: assert property (cmd_wr && crc_en_r && pre2_r ##6 cmd_wr && $stable(crc_en_r) && $stable(pre2_r)
                                |=> flags_r[FLG_CCD]) // R9
      else $error("six clock write spacing not flagged");
   a_mask_dbi: assert property (dm_en_r && dbi_en_r |=> flags_r[FLG_DMDBI]) // R14
      else $error("mask with inversion not flagged");

   c_bl8_burst: cover property ($rose(wdata_valid) && !wdata_chop);
   c_auto_pre:  cover property (|ap_done);
   c_back2back: cover property (cmd_wr ##4 cmd_wr);
   c_wtr_read:  cover property (cmd_rd && wtr_l_cnt_r != '0);

endmodule
`default_nettype wire

// ==== wtt_pkg.sv ====
// constants and register map of the write turnaround timing block
`default_nettype none
package wtt_pkg;

   // ********************************************
   // register port
   // ********************************************
   localparam int          ADDR_W   = 8;
   localparam int          DATA_W   = 32;
   localparam logic [7:0]  REG_MODE = 8'h00;
   localparam logic [7:0]  REG_LAT  = 8'h04;
   localparam logic [7:0]  REG_TWR  = 8'h08;
   localparam logic [7:0]  REG_TWTR = 8'h0C;
   localparam logic [7:0]  REG_STAT = 8'h10;
   localparam logic [7:0]  REG_FLAG = 8'h14;

   // ********************************************
   // field positions
   // ********************************************
   localparam int MODE_BL_LSB  = 0;
   localparam int MODE_DBI     = 2;
   localparam int MODE_CRC     = 3;
   localparam int MODE_DM      = 4;
   localparam int MODE_PRE2    = 5;
   localparam int LAT_AL_LSB   = 0;
   localparam int LAT_CWL_LSB  = 8;
   localparam int LAT_W        = 5;
   localparam int TMR_W        = 8;
   localparam int FLD0_LSB     = 0;
   localparam int FLD1_LSB     = 8;
   localparam int FLD2_LSB     = 16;
   localparam int FLD3_LSB     = 24;
   localparam int FLG_TWR      = 0;
   localparam int FLG_WTR      = 1;
   localparam int FLG_CWL      = 2;
   localparam int FLG_CCD      = 3;
   localparam int FLG_DMDBI    = 4;
   localparam int FLG_W        = 5;
   localparam int STAT_OPEN    = 0;
   localparam int STAT_BUSY    = 8;
   localparam int STAT_WIN     = 16;

   // ********************************************
   // burst modes and timing
   // ********************************************
   localparam logic [1:0] BL_MODE_8     = 2'h0;
   localparam logic [1:0] BL_MODE_OTF   = 2'h1;
   localparam logic [1:0] BL_MODE_BC4   = 2'h2;
   localparam logic [2:0] BURST_CLK_8   = 3'h4;
   localparam logic [2:0] BURST_CLK_BC4 = 3'h2;
   localparam logic [4:0] CWL_MIN       = 5'h09;
   localparam logic [3:0] CCD_FORBID    = 4'h6;
   localparam logic [5:0] WL_TAP_OFS    = 6'h02;

   // ********************************************
   // banks and write pipeline
   // ********************************************
   localparam int NBANK      = 8;
   localparam int BANK_W     = 3;
   localparam int BG_BIT     = 2;
   localparam int SR_DEPTH   = 64;
   localparam int SR_W       = 6;
   localparam int E_V        = 5;
   localparam int E_BANK_LSB = 2;
   localparam int E_OTF      = 1;
   localparam int E_FIX      = 0;

   // ********************************************
   // reset values
   // ********************************************
   localparam logic [1:0]       BL_MODE_RST    = 2'h0;
   localparam logic [LAT_W-1:0] AL_RST         = 5'h00;
   localparam logic [LAT_W-1:0] CWL_RST        = 5'h09;
   localparam logic [TMR_W-1:0] TWR_RST        = 8'h0C;
   localparam logic [TMR_W-1:0] TWR_DBI_RST    = 8'h0D;
   localparam logic [TMR_W-1:0] TWR_CRC_RST    = 8'h0E;
   localparam logic [TMR_W-1:0] TWTR_S_RST     = 8'h02;
   localparam logic [TMR_W-1:0] TWTR_L_RST     = 8'h06;
   localparam logic [TMR_W-1:0] TWTR_S_CRC_RST = 8'h03;
   localparam logic [TMR_W-1:0] TWTR_L_CRC_RST = 8'h07;

endpackage
`default_nettype wire

// ==== wtt_bank.sv ====
// per-bank open state, write recovery timer and auto precharge
`timescale 1ns/1ps
`default_nettype none
module wtt_bank
   import wtt_pkg::*;
(
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             nrst,
   // commands aimed at this bank
   input  wire logic             act,
   input  wire logic             wr,
   input  wire logic             ap,
   input  wire logic             pre,
   // end of a data burst to this bank
   input  wire logic             burst_done,
   input  wire logic [TMR_W-1:0] twr_val,
   // state
   output logic                  bank_open,
   output logic                  bank_busy,
   output logic                  ap_pulse
);

   typedef enum logic [1:0] {BK_IDLE, BK_OPEN, BK_CLOSING} wtt_bank_t;

   wtt_bank_t        state_r;
   logic [2:0]       pend_r;
   logic [TMR_W-1:0] tmr_r;

   assign bank_busy = (pend_r != 3'h0) || (tmr_r != '0);
   assign bank_open = (state_r != BK_IDLE);

   // ********************************************
   // bursts in flight
   // ********************************************
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pend_r <= 3'h0;
      end else if (wr && !burst_done) begin
         pend_r <= pend_r + 3'h1;
      end else if (!wr && burst_done) begin
         pend_r <= pend_r - 3'h1;
      end
   end

   // recovery starts at the edge after the last clock of the burst slot
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         tmr_r <= '0;
      end else if (burst_done) begin
         tmr_r <= twr_val; // R3
      end else if (tmr_r != '0) begin
         tmr_r <= tmr_r - 8'h01;
      end
   end

   // ********************************************
   // bank state
   // ********************************************
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_r  <= BK_IDLE;
         ap_pulse <= 1'b0;
      end else begin
         ap_pulse <= 1'b0;
         case (state_r)
            BK_IDLE: begin
               if (act) begin
                  state_r <= BK_OPEN;
               end
            end
            BK_OPEN: begin
               if (pre) begin
                  state_r <= BK_IDLE;
               end else if (wr && ap) begin
                  state_r <= BK_CLOSING; // R13
               end
            end
            BK_CLOSING: begin
               // a plain precharge here is redundant and ignored
               if (!bank_busy) begin
                  state_r  <= BK_IDLE; // R13
                  ap_pulse <= 1'b1;
               end
            end
            default: begin
               state_r <= BK_IDLE;
            end
         endcase
      end
   end

   // ********************************************
   // checks
   // ********************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   a_ap_close: assert property (state_r == BK_CLOSING && !bank_busy |=> state_r == BK_IDLE && ap_pulse) // R13
      else $error("auto precharge did not close the bank");
   a_wr_keeps_open: assert property (state_r == BK_OPEN && wr && !ap && !pre |=> state_r == BK_OPEN) // R13
      else $error("plain write closed the bank");
   a_recovery_hold: assert property (burst_done && !wr && twr_val >= 8'h02 |=> bank_busy[*2]) // R3
      else $error("write recovery ended early");

endmodule
`default_nettype wire

// ==== wtt_ctrl.sv ====
// controller model: turns bench requests into one-cycle command strobes
`timescale 1ns/1ps
`default_nettype none
module wtt_ctrl
   import wtt_pkg::*;
(
   // request from the bench
   input  wire logic       go,
   input  wire logic [1:0] kind,
   // command strobes
   output logic            cmd_act,
   output logic            cmd_wr,
   output logic            cmd_rd,
   output logic            cmd_pre
);
   // the bench paces requests; spacing is held there, not here
   assign cmd_act = go && kind == 2'h0;
   assign cmd_wr  = go && kind == 2'h1;
   assign cmd_rd  = go && kind == 2'h2;
   assign cmd_pre = go && kind == 2'h3;
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench of the write timing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import wtt_pkg::*;
   logic              ref_clk = 1'b0;
   logic              nrst = 1'b0;
   logic [ADDR_W-1:0] ra = '0;
   logic [DATA_W-1:0] wd = '0;
   logic [DATA_W-1:0] q;
   logic              we = 1'b0;
   logic              re = 1'b0;
   logic              go = 1'b0;
   logic [1:0]        kd = 2'h0;
   logic [BANK_W-1:0] bk = '0;
   logic              a10 = 1'b0;
   logic              a12 = 1'b0;
   wire logic [DATA_W-1:0] rdat;
   wire logic              act, wr, rd, pre, wv, wc;
   wire logic [BANK_W-1:0] wb;
   wire logic [NBANK-1:0]  apd, bop;
   int bad_count = 0;
   int samples_checked = 0;
   int n, wl, al, b, d;
   int md[5] = '{0, 1, 1, 2, 3};
   int fm[9] = '{0, 0, 4, 26, 0, 0, 0, 24, 24};
   wtt_ctrl ctl (.go(go), .kind(kd), .cmd_act(act), .cmd_wr(wr), .cmd_rd(rd), .cmd_pre(pre));
   wtt_write_timing uut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(ra), .reg_wdata(wd), .reg_we(we),
      .reg_re(re), .reg_rdata(rdat), .cmd_act(act), .cmd_wr(wr), .cmd_rd(rd), .cmd_pre(pre),
      .cmd_bank(bk), .cmd_a10(a10), .cmd_a12(a12), .wdata_valid(wv), .wdata_chop(wc),
      .wdata_bank(wb), .ap_done(apd), .bank_open(bop));
   always #25 ref_clk = ~ref_clk;
   // *****
   // tasks
   // *****
   task automatic conclude;
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("[ERR] %s exp %h got %h", s, e, g);
         bad_count++;
      end
   endtask
   task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      ra <= a;
      wd <= v;
      we <= w;
      re <= ~w;
      @(posedge ref_clk);
      we <= 1'b0;
      re <= 1'b0;
      #1 q = rdat;
   endtask
   task automatic cmd(input logic [1:0] k, input logic [2:0] c, input logic x, input logic y);
      @(posedge ref_clk);
      go <= 1'b1;
      kd <= k;
      bk <= c;
      a10 <= x;
      a12 <= y;
      @(posedge ref_clk);
      go <= 1'b0;
   endtask
   // expected recovery or turnaround for a mode, command and group
   function automatic int lim(input int m, input bit r, input bit o);
      logic [7:0] t;
      if (!r)
         t = m == 24 ? TWR_CRC_RST : m == 4 ? TWR_DBI_RST : TWR_RST;
      else
         t = m == 24 ? (o ? TWTR_S_CRC_RST : TWTR_L_CRC_RST) : (o ? TWTR_S_RST : TWTR_L_RST);
      return int'(t);
   endfunction
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      conclude();
   end
   initial begin
      void'($urandom(75340));
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      rw(0, REG_LAT, 0);
      chk("lat", {19'h0, CWL_RST, 3'h0, AL_RST}, q);
      rw(0, REG_TWR, 0);
      chk("twr", {8'h0, TWR_CRC_RST, TWR_DBI_RST, TWR_RST}, q);
      rw(0, REG_TWTR, 0);
      chk("twtr", {TWTR_L_CRC_RST, TWTR_S_CRC_RST, TWTR_L_RST, TWTR_S_RST}, q);
      rw(0, 8'hFC, 0);
      chk("unmapped", 0, q);
      #50 chk("rdata idle", 0, rdat);
      for (int i = 0; i < 8; i++) cmd(2'h0, i[2:0], 1'b0, 1'b0);
      rw(0, REG_STAT, 0);
      chk("open", 32'hFF, q & 32'hFF);
      for (int i = 0; i < 5; i++) begin
         al = $urandom_range(3);
         wl = al + 10 + $urandom_range(3);
         b = $urandom_range(7);
         rw(1, REG_LAT, {19'h0, 5'(wl - al), 3'h0, 5'(al)});
         rw(1, REG_MODE, md[i]);
         cmd(2'h1, b[2:0], 1'b0, i != 2);
         n = 1;
         #1;
         while (wv !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            #1 n++;
         end
         chk("latency", wl, n);
         chk("chop", i == 2 || i == 3, wc);
         chk("bank", b, wb);
         n = 0;
         repeat (6) begin
            n += (wv === 1'b1);
            @(posedge ref_clk);
            #1;
         end
         chk("beats", (i == 2 || i == 3) ? 2 : 4, n);
         repeat (30) @(posedge ref_clk);
      end
      rw(1, REG_LAT, 32'h00000900);
      rw(1, REG_MODE, 0);
      wl = 9;
      for (int i = 0; i < 2; i++) begin
         b = $urandom_range(7);
         cmd(2'h0, b[2:0], 1'b0, 1'b0);
         cmd(2'h1, b[2:0], i[0], 1'b1);
         n = 1;
         #1;
         while (apd[b] !== 1'b1 && n < 60) begin
            @(posedge ref_clk);
            #1 n++;
         end
         d = wl + 3 + int'(TWR_RST);
         chk("autopre", 1, i[0] ? (n >= d && n <= d + 3) : (n == 60));
         chk("open after", !i[0], bop[b]);
      end
      // precharge and read placed one cycle early or exactly at the limit
      for (int i = 0; i < 9; i++) begin
         b = $urandom_range(7);
         rw(1, REG_MODE, fm[i]);
         rw(1, REG_FLAG, 32'h1F);
         cmd(2'h0, b[2:0], 1'b0, 1'b0);
         cmd(2'h1, b[2:0], 1'b0, 1'b1);
         d = wl + (fm[i][1] ? 2 : 4) + lim(fm[i] & 28, i > 3, i == 5 || i == 8) - ((i == 1 || i == 6) ? 0 : 1);
         repeat (d - 2) @(posedge ref_clk);
         cmd(i > 3 ? 2'h2 : 2'h3, (i == 5 || i == 8) ? b[2:0] ^ 3'h4 : b[2:0], 1'b0, 1'b0);
         rw(0, REG_FLAG, 0);
         chk("flag", ((i == 1 || i == 6) ? 0 : 1) << (i > 3), q & 32'h3);
         repeat (30) @(posedge ref_clk);
      end
      rw(1, REG_MODE, 32'h20);
      rw(1, REG_FLAG, 32'h1F);
      rw(0, REG_FLAG, 0);
      chk("cwl flag", 32'h4, q & 32'h1C);
      rw(1, REG_MODE, 32'h14);
      rw(1, REG_FLAG, 32'h1F);
      rw(0, REG_FLAG, 0);
      chk("dm dbi", 32'h10, q & 32'h1C);
      rw(1, REG_LAT, 32'h00000A00);
      rw(1, REG_MODE, 32'h28);
      for (int g = 6; g < 8; g++) begin
         rw(1, REG_FLAG, 32'h1F);
         cmd(2'h1, 3'h1, 1'b0, 1'b1);
         repeat (g - 2) @(posedge ref_clk);
         cmd(2'h1, 3'h5, 1'b0, 1'b1);
         rw(0, REG_FLAG, 0);
         chk("ccd flag", g == 6 ? 32'h8 : 32'h0, q & 32'h1C);
         repeat (40) @(posedge ref_clk);
      end
      conclude();
   end
endmodule
`default_nettype wire
